// *** design/ssfe_pkg.sv ***
// Shared constants, field layouts and types of the serial status engine.
package ssfe_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam int          ADDR_W       = 8;
	localparam logic [7:0]  OFS_CTRL     = 8'h00;
	localparam logic [7:0]  OFS_CTRL_CLR = 8'h04;
	localparam logic [7:0]  OFS_CTRL_SET = 8'h08;
	localparam logic [7:0]  OFS_CTRL_INV = 8'h0C;
	localparam logic [7:0]  OFS_STATUS   = 8'h10;
	localparam logic [7:0]  OFS_DATA     = 8'h20;
	localparam logic [7:0]  OFS_BAUD     = 8'h30;

	// ****************************************
	// Control fields
	// ****************************************
	localparam int          CTL_EVT      = 0;
	localparam int          CTL_MASTER   = 5;
	localparam int          CTL_CPOL     = 6;
	localparam int          CTL_CPHA     = 8;
	localparam int          CTL_MODE_LO  = 10;
	localparam int          CTL_ON       = 15;
	localparam int          CTL_ENH      = 16;
	localparam int          CTL_FRAMED   = 31;
	localparam logic [31:0] CTRL_MASK    = 32'h8001_8D61;
	localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
	localparam logic [7:0]  BAUD_RESET   = 8'h03;

	// ****************************************
	// Status fields
	// ****************************************
	localparam int          ST_RXCNT_LO    = 24;
	localparam int          ST_TXCNT_LO    = 16;
	localparam int          ST_BUSY        = 11;
	localparam int          ST_UNDERRUN    = 8;
	localparam int          ST_SHIFT_EMPTY = 7;
	localparam int          ST_OVF         = 6;
	localparam int          ST_RX_EMPTY    = 5;
	localparam int          ST_TX_EMPTY    = 3;
	localparam int          ST_TX_FULL     = 1;
	localparam int          ST_RX_FULL     = 0;

	// ****************************************
	// Word widths and FIFO depths
	// ****************************************
	localparam logic [1:0]  MODE_8       = 2'h0;
	localparam logic [1:0]  MODE_16      = 2'h1;
	localparam logic [1:0]  MODE_32      = 2'h2;
	localparam logic [5:0]  BITS_8       = 6'h08;
	localparam logic [5:0]  BITS_16      = 6'h10;
	localparam logic [5:0]  BITS_32      = 6'h20;
	localparam logic [4:0]  DEPTH_8      = 5'h10;
	localparam logic [4:0]  DEPTH_16     = 5'h08;
	localparam logic [4:0]  DEPTH_32     = 5'h04;
	localparam logic [4:0]  DEPTH_LEGACY = 5'h01;
	localparam int          FIFO_SLOTS   = 16;

	// Decoded configuration
	typedef struct packed {
		logic       on;
		logic       master;
		logic       framed;
		logic       cpol;
		logic       cpha;
		logic       enh;
		logic       evtEn;
		logic [1:0] width;
	} ssfe_cfg_t;

	// Shifter sequence
	typedef enum logic [1:0] {
		SH_IDLE = 2'b00,
		SH_RUN  = 2'b01,
		SH_TAIL = 2'b11
	} ssfe_state_t;

endpackage

// *** design/ssfe_engine.sv ***
// Serial peripheral engine with FIFOs, status register and master or slave link.
`timescale 1ns/100ps

// Function
// - Role master or slave is chosen by a control bit.
// - Idle clock level and sampling edge are both configurable, four formats.
// - Framed mode uses a frame sync pulse to mark each word start.
// - Word width selectable as 8, 16 or 32 bits.
// - Separate receive and transmit FIFOs, 16/8/4 entries by width.
// - Optional event pulse after every completed word.
// - Engine has no stop input, so it keeps running in low power states.
// - Control register has clear, set and invert aliases acting on written ones.
// - Status field reports receive FIFO element count.
// - Status field reports transmit FIFO element count.
// - Activity flag is 1 during a transaction, 0 when idle.
// - Underrun flag sets when framed slave word starts with empty transmit buffer.
// - Underrun clears only when the engine is switched off.
// - Shifter empty flag is 1 when the shift register holds no word.
// - Word arriving into a full receive buffer is dropped and sets overflow.
// - Overflow set by hardware only; software clears it by writing 0.
// - Receive empty flag is 1 when the receive FIFO element count is zero.
// - Transmit empty sets when the last word moves into the shifter.
// - Transmit empty clears when software writes the data port.
// - Unused status bits read as zero and ignore writes.
module ssfe_engine (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [31:0] regRdata,
	input  wire logic        sckIn,
	output logic             sckOut,
	output logic             sckOe,
	input  wire logic        serialIn,
	output logic             serialOut,
	input  wire logic        selectInN,
	output logic             selectOutN,
	input  wire logic        frameSyncIn,
	output logic             frameSyncOut,
	output logic             frameSyncOe,
	output logic             wordEvent
);

	// ****************************************
	// Declarations
	// ****************************************
	localparam int PTR_W = $clog2(ssfe_pkg::FIFO_SLOTS);

	logic [31:0]            ctrlQ;
	logic [7:0]             baudQ;
	ssfe_pkg::ssfe_cfg_t    cfg;
	logic [5:0]             wordBits;
	logic [4:0]             depth;
	logic [3:0]             sync1Q;
	logic [3:0]             sync2Q;
	logic [3:0]             pinRaw;
	logic                   sckPrevQ;
	logic                   fsPrevQ;
	logic                   sckS;
	logic                   sdiS;
	logic                   ssS;
	logic                   fsS;
	ssfe_pkg::ssfe_state_t  stateQ;
	ssfe_pkg::ssfe_state_t  stateD;
	logic [7:0]             divCntQ;
	logic [6:0]             edgeCntQ;
	logic [5:0]             bitCntQ;
	logic [31:0]            txShQ;
	logic [31:0]            rxShQ;
	logic [31:0]            txMemQ [ssfe_pkg::FIFO_SLOTS];
	logic [31:0]            rxMemQ [ssfe_pkg::FIFO_SLOTS];
	logic [PTR_W-1:0]       txWrQ;
	logic [PTR_W-1:0]       txRdQ;
	logic [PTR_W-1:0]       rxWrQ;
	logic [PTR_W-1:0]       rxRdQ;
	logic [4:0]             txCountQ;
	logic [4:0]             rxCountQ;
	logic                   underrunQ;
	logic                   ovfQ;
	logic [31:0]            statusWord;
	logic [31:0]            rdMux;
	logic [31:0]            loadWord;
	logic [31:0]            rxNext;
	logic [31:0]            rxWord;
	logic                   mstEdge;
	logic                   slvRise;
	logic                   slvFall;
	logic                   leadEv;
	logic                   trailEv;
	logic                   sampleEv;
	logic                   shiftEv;
	logic                   wordDone;
	logic                   txAvail;
	logic                   mstStart;
	logic                   slvStart;
	logic                   startEv;
	logic                   popTx;
	logic                   pushTx;
	logic                   pushRx;
	logic                   popRx;
	logic                   ovfEv;
	logic                   underrunEv;
	logic                   slvAbort;
	logic                   lastEdge;
	logic                   wrData;
	logic                   rdData;
	logic                   clrOvf;

	// ****************************************
	// Configuration decode
	// ****************************************
	// Fields pulled out of the control word
	always_comb begin
		cfg.on     = ctrlQ[ssfe_pkg::CTL_ON];
		cfg.master = ctrlQ[ssfe_pkg::CTL_MASTER];
		cfg.framed = ctrlQ[ssfe_pkg::CTL_FRAMED];
		cfg.cpol   = ctrlQ[ssfe_pkg::CTL_CPOL];
		cfg.cpha   = ctrlQ[ssfe_pkg::CTL_CPHA];
		cfg.enh    = ctrlQ[ssfe_pkg::CTL_ENH];
		cfg.evtEn  = ctrlQ[ssfe_pkg::CTL_EVT];
		cfg.width  = ctrlQ[ssfe_pkg::CTL_MODE_LO +: 2];
	end

	// Width and depth; code 3 behaves as 32 bits
	always_comb begin
		unique case (cfg.width)
			ssfe_pkg::MODE_8: begin
				wordBits = ssfe_pkg::BITS_8;
				depth    = ssfe_pkg::DEPTH_8;
			end
			ssfe_pkg::MODE_16: begin
				wordBits = ssfe_pkg::BITS_16;
				depth    = ssfe_pkg::DEPTH_16;
			end
			default: begin
				wordBits = ssfe_pkg::BITS_32;
				depth    = ssfe_pkg::DEPTH_32;
			end
		endcase
		// Without the enhanced buffer each side holds a single word
		if (!cfg.enh) begin
			depth = ssfe_pkg::DEPTH_LEGACY;
		end
	end

	// ****************************************
	// Register bus
	// ****************************************
	assign wrData = regWr && (regAddr == ssfe_pkg::OFS_DATA);
	assign rdData = regRd && (regAddr == ssfe_pkg::OFS_DATA);
	assign clrOvf = regWr && (regAddr == ssfe_pkg::OFS_STATUS) && !regWdata[ssfe_pkg::ST_OVF];

	// Control word and its bit-manipulation aliases
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrlQ <= ssfe_pkg::CTRL_RESET;
		end else if (regWr) begin
			unique case (regAddr)
				ssfe_pkg::OFS_CTRL:     ctrlQ <= regWdata & ssfe_pkg::CTRL_MASK;
				ssfe_pkg::OFS_CTRL_CLR: ctrlQ <= ctrlQ & ~regWdata;
				ssfe_pkg::OFS_CTRL_SET: ctrlQ <= ctrlQ | (regWdata & ssfe_pkg::CTRL_MASK);
				ssfe_pkg::OFS_CTRL_INV: ctrlQ <= ctrlQ ^ (regWdata & ssfe_pkg::CTRL_MASK);
				default:                ctrlQ <= ctrlQ;
			endcase
		end
	end

	// Half-period divider for master clock
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			baudQ <= ssfe_pkg::BAUD_RESET;
		end else if (regWr && (regAddr == ssfe_pkg::OFS_BAUD)) begin
			baudQ <= regWdata[7:0];
		end
	end

	// Status word; unlisted bits stay zero
	always_comb begin
		statusWord                                 = 32'h0000_0000;
		statusWord[ssfe_pkg::ST_RXCNT_LO +: 5]     = rxCountQ;
		statusWord[ssfe_pkg::ST_TXCNT_LO +: 5]     = txCountQ;
		statusWord[ssfe_pkg::ST_BUSY]              = (stateQ != ssfe_pkg::SH_IDLE) || mstStart;
		statusWord[ssfe_pkg::ST_UNDERRUN]          = underrunQ;
		statusWord[ssfe_pkg::ST_SHIFT_EMPTY]       = (stateQ == ssfe_pkg::SH_IDLE);
		statusWord[ssfe_pkg::ST_OVF]               = ovfQ;
		statusWord[ssfe_pkg::ST_RX_EMPTY]          = (rxCountQ == 5'h00);
		statusWord[ssfe_pkg::ST_TX_EMPTY]          = (txCountQ == 5'h00);
		statusWord[ssfe_pkg::ST_TX_FULL]           = (txCountQ >= depth);
		statusWord[ssfe_pkg::ST_RX_FULL]           = (rxCountQ >= depth);
	end

	// Read mux; unmapped offsets answer zero
	always_comb begin
		unique case (regAddr)
			ssfe_pkg::OFS_CTRL,
			ssfe_pkg::OFS_CTRL_CLR,
			ssfe_pkg::OFS_CTRL_SET,
			ssfe_pkg::OFS_CTRL_INV: rdMux = ctrlQ;
			ssfe_pkg::OFS_STATUS:   rdMux = statusWord;
			ssfe_pkg::OFS_DATA:     rdMux = (rxCountQ != 5'h00) ? rxMemQ[rxRdQ] : 32'h0000_0000;
			ssfe_pkg::OFS_BAUD:     rdMux = {24'h00_0000, baudQ};
			default:                rdMux = 32'h0000_0000;
		endcase
	end

	// Read data stand one cycle after the strobe only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			regRdata <= 32'h0000_0000;
		end else begin
			regRdata <= regRd ? rdMux : 32'h0000_0000;
		end
	end

	// ****************************************
	// Pin synchronisers
	// ****************************************
	assign pinRaw = {frameSyncIn, selectInN, serialIn, sckIn};

	// Two stages per pin; link runs asynchronous to clk
	generate
		for (genvar i = 0; i < 4; i++) begin : gSync
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					sync1Q[i] <= 1'b0;
					sync2Q[i] <= 1'b0;
				end else begin
					sync1Q[i] <= pinRaw[i];
					sync2Q[i] <= sync1Q[i];
				end
			end
		end
	endgenerate

	assign sckS = sync2Q[0];
	assign sdiS = sync2Q[1];
	assign ssS  = sync2Q[2];
	assign fsS  = sync2Q[3];

	// Delayed copies for edge detection
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sckPrevQ <= 1'b0;
			fsPrevQ  <= 1'b0;
		end else begin
			sckPrevQ <= sckS;
			fsPrevQ  <= fsS;
		end
	end

	// ****************************************
	// Link events
	// ****************************************
	assign slvRise  = sckS && !sckPrevQ;
	assign slvFall  = !sckS && sckPrevQ;
	assign mstEdge  = cfg.master && (stateQ != ssfe_pkg::SH_IDLE) && (divCntQ == baudQ);
	// Leading edge leaves the idle level
	assign leadEv   = cfg.master ? (mstEdge && (sckOut == cfg.cpol)) : (cfg.cpol ? slvFall : slvRise);
	assign trailEv  = cfg.master ? (mstEdge && (sckOut != cfg.cpol)) : (cfg.cpol ? slvRise : slvFall);
	assign sampleEv = (stateQ == ssfe_pkg::SH_RUN) && (cfg.cpha ? trailEv : leadEv);
	assign shiftEv  = (stateQ == ssfe_pkg::SH_RUN) && (cfg.cpha ? leadEv : trailEv);
	assign wordDone = sampleEv && (bitCntQ == (wordBits - 6'h01));
	assign lastEdge = mstEdge && (edgeCntQ == ({1'b0, wordBits} + {1'b0, wordBits} - 7'h01));

	assign txAvail    = (txCountQ != 5'h00);
	assign mstStart   = cfg.on && cfg.master && (stateQ == ssfe_pkg::SH_IDLE) && txAvail;
	// Framed slave starts on sync rise, plain slave on select low
	assign slvStart   = cfg.on && !cfg.master && (stateQ == ssfe_pkg::SH_IDLE) &&
		(cfg.framed ? (fsS && !fsPrevQ) : !ssS);
	assign startEv    = mstStart || slvStart;
	assign popTx      = startEv && txAvail;
	assign underrunEv = slvStart && cfg.framed && !txAvail;
	assign slvAbort   = !cfg.master && !cfg.framed && ssS;

	// ****************************************
	// Shifter sequence
	// ****************************************
	always_comb begin
		stateD = stateQ;
		unique case (stateQ)
			ssfe_pkg::SH_IDLE: begin
				if (startEv) begin
					stateD = ssfe_pkg::SH_RUN;
				end
			end
			ssfe_pkg::SH_RUN: begin
				if (cfg.master && lastEdge) begin
					stateD = ssfe_pkg::SH_TAIL;
				end else if (!cfg.master && (wordDone || slvAbort)) begin
					stateD = ssfe_pkg::SH_IDLE;
				end
			end
			ssfe_pkg::SH_TAIL: begin
				// Half period of hold with select still asserted before release
				if (divCntQ == baudQ) begin
					stateD = ssfe_pkg::SH_IDLE;
				end
			end
			default: stateD = ssfe_pkg::SH_IDLE;
		endcase
		if (!cfg.on) begin
			stateD = ssfe_pkg::SH_IDLE;
		end
	end

	// Sequence state keeps running regardless of system power state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stateQ <= ssfe_pkg::SH_IDLE;
		end else begin
			stateQ <= stateD;
		end
	end

	// Divider, edge and bit counters
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			divCntQ  <= 8'h00;
			edgeCntQ <= 7'h00;
			bitCntQ  <= 6'h00;
		end else begin
			divCntQ  <= ((stateQ != ssfe_pkg::SH_IDLE) && (divCntQ != baudQ)) ? divCntQ + 8'h01 : 8'h00;
			if (startEv) begin
				edgeCntQ <= 7'h00;
				bitCntQ  <= 6'h00;
			end else begin
				if (mstEdge) begin
					edgeCntQ <= edgeCntQ + 7'h01;
				end
				if (sampleEv) begin
					bitCntQ <= bitCntQ + 6'h01;
				end
			end
		end
	end

	// Left-align the outgoing word so the first bit sits at bit 31
	always_comb begin
		loadWord = 32'h0000_0000;
		if (txAvail) begin
			unique case (cfg.width)
				ssfe_pkg::MODE_8:  loadWord = {txMemQ[txRdQ][7:0], 24'h00_0000};
				ssfe_pkg::MODE_16: loadWord = {txMemQ[txRdQ][15:0], 16'h0000};
				default:           loadWord = txMemQ[txRdQ];
			endcase
		end
	end

	// Received word right-aligned, upper bits cleared
	assign rxNext = {rxShQ[30:0], sdiS};
	always_comb begin
		unique case (cfg.width)
			ssfe_pkg::MODE_8:  rxWord = {24'h00_0000, rxNext[7:0]};
			ssfe_pkg::MODE_16: rxWord = {16'h0000, rxNext[15:0]};
			default:           rxWord = rxNext;
		endcase
	end

	// Shift registers and serial output; empty buffer sends zeros
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			txShQ     <= 32'h0000_0000;
			rxShQ     <= 32'h0000_0000;
			serialOut <= 1'b0;
		end else begin
			if (startEv) begin
				// Phase 0 must present its first bit before the first edge
				if (!cfg.cpha) begin
					serialOut <= loadWord[31];
					txShQ     <= {loadWord[30:0], 1'b0};
				end else begin
					txShQ     <= loadWord;
				end
			end else if (shiftEv) begin
				serialOut <= txShQ[31];
				txShQ     <= {txShQ[30:0], 1'b0};
			end
			if (sampleEv) begin
				rxShQ <= rxNext;
			end
		end
	end

	// ****************************************
	// Master pins
	// ****************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sckOut       <= 1'b0;
			sckOe        <= 1'b0;
			selectOutN   <= 1'b1;
			frameSyncOut <= 1'b0;
			frameSyncOe  <= 1'b0;
		end else begin
			sckOe       <= cfg.on && cfg.master;
			frameSyncOe <= cfg.on && cfg.master && cfg.framed;
			selectOutN  <= !(cfg.master && (stateD != ssfe_pkg::SH_IDLE));
			if ((stateQ == ssfe_pkg::SH_RUN) && mstEdge) begin
				sckOut <= !sckOut;
			end else if (stateQ != ssfe_pkg::SH_RUN) begin
				sckOut <= cfg.cpol;
			end
			// Sync pulse covers the first bit of each framed word
			if (mstStart && cfg.framed) begin
				frameSyncOut <= 1'b1;
			end else if (!cfg.on || (mstEdge && (edgeCntQ == 7'h01))) begin
				frameSyncOut <= 1'b0;
			end
		end
	end

	// ****************************************
	// Transmit FIFO
	// ****************************************
	assign pushTx = wrData && cfg.on && (txCountQ < depth);

	always_ff @(posedge clk) begin
		if (pushTx) begin
			txMemQ[txWrQ] <= regWdata;
		end
	end

	// Switching off flushes; full FIFO drops extra writes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			txWrQ    <= '0;
			txRdQ    <= '0;
			txCountQ <= 5'h00;
		end else if (!cfg.on) begin
			txWrQ    <= '0;
			txRdQ    <= '0;
			txCountQ <= 5'h00;
		end else begin
			if (pushTx) begin
				txWrQ <= txWrQ + 1'b1;
			end
			if (popTx) begin
				txRdQ <= txRdQ + 1'b1;
			end
			txCountQ <= txCountQ + {4'h0, pushTx} - {4'h0, popTx};
		end
	end

	// ****************************************
	// Receive FIFO
	// ****************************************
	assign pushRx = wordDone && (rxCountQ < depth);
	assign ovfEv  = wordDone && (rxCountQ >= depth);
	assign popRx  = rdData && (rxCountQ != 5'h00);

	always_ff @(posedge clk) begin
		if (pushRx) begin
			rxMemQ[rxWrQ] <= rxWord;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rxWrQ    <= '0;
			rxRdQ    <= '0;
			rxCountQ <= 5'h00;
		end else if (!cfg.on) begin
			rxWrQ    <= '0;
			rxRdQ    <= '0;
			rxCountQ <= 5'h00;
		end else begin
			if (pushRx) begin
				rxWrQ <= rxWrQ + 1'b1;
			end
			if (popRx) begin
				rxRdQ <= rxRdQ + 1'b1;
			end
			rxCountQ <= rxCountQ + {4'h0, pushRx} - {4'h0, popRx};
		end
	end

	// ****************************************
	// Error flags and word event
	// ****************************************
	// Underrun survives everything but switching off
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			underrunQ <= 1'b0;
		end else if (!cfg.on) begin
			underrunQ <= 1'b0;
		end else if (underrunEv) begin
			underrunQ <= 1'b1;
		end
	end

	// Set beats a same-cycle clear so no overflow goes unseen
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ovfQ <= 1'b0;
		end else begin
			ovfQ <= ovfEv || (ovfQ && !clrOvf);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wordEvent <= 1'b0;
		end else begin
			wordEvent <= wordDone && cfg.evtEn;
		end
	end

endmodule

// *** test/ssfe_engine_props.sv ***
// Port-level assertions for the serial status engine.
`timescale 1ns/100ps
module ssfe_engine_props (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [7:0]  regAddr,
	input wire logic        regRd,
	input wire logic [31:0] regRdata,
	input wire logic        frameSyncOut,
	input wire logic        frameSyncOe,
	input wire logic        wordEvent
);
	// ****************
	// Status and link checks
	// ****************
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Status word stands only the cycle after its strobe
	sequence s_stRd;
		$past(regRd) && $past(regAddr) == ssfe_pkg::OFS_STATUS;
	endsequence
	property p_rsvd; s_stRd |-> (regRdata & 32'hE0E0_F614) == 32'h0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
	property p_rxE; s_stRd |-> regRdata[5] == (regRdata[28:24] == 5'h00); endproperty
	a_rxE: assert property (p_rxE) else $error("rx empty flag");
	property p_txE; s_stRd |-> regRdata[3] == (regRdata[20:16] == 5'h00); endproperty
	a_txE: assert property (p_txE) else $error("tx empty flag");
	property p_dep; s_stRd |-> regRdata[28:24] <= 5'h10 && regRdata[20:16] <= 5'h10; endproperty
	a_dep: assert property (p_dep) else $error("count beyond depth");
	property p_full; s_stRd |-> (!regRdata[1] || regRdata[20:16] != 5'h00) && !(regRdata[0] && regRdata[5]); endproperty
	a_full: assert property (p_full) else $error("full flag");
	// Shifter holding a word means the link is active
	property p_busy; s_stRd ##0 !regRdata[7] |-> regRdata[11]; endproperty
	a_busy: assert property (p_busy) else $error("busy flag");
	property p_evt; wordEvent |=> !wordEvent; endproperty
	a_evt: assert property (p_evt) else $error("event too long");
	property p_frm; frameSyncOut |-> frameSyncOe; endproperty
	a_frm: assert property (p_frm) else $error("sync not driven");
endmodule
bind ssfe_engine ssfe_engine_props chk_u (.clk(clk), .rst(rst), .regAddr(regAddr), .regRd(regRd),
	.regRdata(regRdata), .frameSyncOut(frameSyncOut), .frameSyncOe(frameSyncOe), .wordEvent(wordEvent));

// *** test/ssfe_peer_model.sv ***
// Far-side peripheral model on the engine's master link.
`timescale 1ns/100ps
module ssfe_peer_model (
	input  wire logic       sck,
	input  wire logic       selN,
	input  wire logic       mosi,
	input  wire logic [7:0] reply,
	input  wire logic       phase,
	output logic            miso,
	output logic [7:0]      got
);
	logic [7:0] sh = 8'h00;
	// Phase 0 needs the first bit out before the first edge; phase 1 sends it on that edge
	always @(negedge selN) begin
		if (!phase) begin
			miso = reply[7];
		end
		sh = phase ? reply : {reply[6:0], 1'b0};
	end
	// Sample on rising, next bit on falling, MSB first
	always @(posedge sck) if (!selN) got = {got[6:0], mosi};
	always @(negedge sck) if (!selN) {miso, sh} = {sh, 1'b0};
	// Released line flips so a stale level never passes
	always @(posedge selN) miso = ~miso;
	initial miso = 1'b0;
	initial got = 8'h00;
endmodule

// *** test/ssfe_engine_tb_top.sv ***
// Self-checking bench for the serial status engine.
`timescale 1ns/100ps
module ssfe_engine_tb_top;
	localparam logic [31:0] ON  = 32'h0000_8000;
	localparam logic [31:0] ENH = 32'h0001_0000;
	localparam logic [31:0] MST = 32'h0000_0021;
	localparam logic [31:0] FRM = 32'h8000_0000;
	localparam logic [7:0]  ST  = ssfe_pkg::OFS_STATUS;
	localparam logic [7:0]  DAT = ssfe_pkg::OFS_DATA;
	localparam logic [7:0]  CT  = ssfe_pkg::OFS_CTRL;
	logic        clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, sckIn = 1'b0;
	logic        selectInN = 1'b1, frameSyncIn = 1'b0, serialIn, sckOut, sckOe, serialOut;
	logic        selectOutN, frameSyncOut, frameSyncOe, wordEvent, pha = 1'b0;
	logic [7:0]  regAddr = 8'h00, reply = 8'h3C, got;
	logic [31:0] regWdata = 32'h0, regRdata;
	int          n_errors, compares, n;
	// Engine and its far-side partner
	ssfe_engine dut_u (.clk, .rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .sckIn, .sckOut, .sckOe,
		.serialIn, .serialOut, .selectInN, .selectOutN, .frameSyncIn, .frameSyncOut, .frameSyncOe, .wordEvent);
	ssfe_peer_model peer_u (.sck(sckOut), .selN(selectOutN), .mosi(serialOut), .reply, .phase(pha),
		.miso(serialIn), .got);
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Accesses end on an edge after one idle cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		regAddr <= a;
		regWdata <= v;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		chk(regRdata, e);
		@(posedge clk);
	endtask
	// Bounded wait for the end-of-word pulse
	task automatic waitEvt;
		n = 0;
		while (wordEvent !== 1'b1 && n < 300) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(32'(n < 300), 32'h1);
		repeat (12) @(posedge clk);
	endtask
	task automatic report_and_stop;
		$display("errors=%0d compares=%0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Clock and watchdog
	initial forever #10 clk = ~clk;
	initial begin
		#200000;
		n_errors++;
		report_and_stop();
	end
	// Test sequence
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdc(ST, 32'h0000_00A8);
		rdc(8'h40, 32'h0);
		wr(CT, ENH | 32'h5);
		wr(ssfe_pkg::OFS_CTRL_SET, 32'h20);
		wr(ssfe_pkg::OFS_CTRL_CLR, 32'h1);
		wr(ssfe_pkg::OFS_CTRL_INV, ENH | 32'h100);
		rdc(CT, 32'h0000_0120);
		// Idle slave: fill each width one past depth
		for (int w = 0; w < 3; w++) begin
			wr(CT, ON | ENH | (w << 10));
			for (int i = 0; i <= (16 >> w); i++) wr(DAT, i);
			rdc(ST, ((16 >> w) << 16) | 32'hA2);
			wr(CT, 32'h0);
		end
		// Master word with event
		wr(CT, ON | ENH | MST);
		wr(DAT, 32'hA5);
		rdc(ST, 32'h0000_0828);
		chk(sckOe, 32'h1);
		waitEvt();
		rdc(ST, 32'h0100_0088);
		rdc(DAT, 32'h3C);
		chk(got, 32'hA5);
		// Second word into a one-deep receive buffer
		wr(CT, ON | MST);
		wr(DAT, 32'h1);
		wr(DAT, 32'h2);
		reply <= 8'h5A;
		waitEvt();
		waitEvt();
		rdc(ST, 32'h0100_00C9);
		wr(ST, 32'h40);
		rdc(ST, 32'h0100_00C9);
		wr(ST, 32'h0);
		rdc(ST, 32'h0100_0089);
		rdc(DAT, 32'h3C);
		// Idle-high clock, shift on leading edge, sample on trailing edge
		wr(CT, ON | MST | 32'h140);
		pha <= 1'b1;
		reply <= 8'hC3;
		wr(DAT, 32'h96);
		waitEvt();
		rdc(DAT, 32'hC3);
		chk(got, 32'h96);
		pha <= 1'b0;
		// Framed master, then framed slave with nothing queued
		wr(CT, ON | MST | FRM);
		wr(DAT, 32'h7);
		waitEvt();
		wr(CT, 32'h0);
		wr(CT, ON | FRM);
		frameSyncIn <= 1'b1;
		repeat (16) begin
			repeat (4) @(posedge clk);
			sckIn <= ~sckIn;
			frameSyncIn <= 1'b0;
		end
		repeat (8) @(posedge clk);
		rdc(ST, 32'h0100_0189);
		chk({sckOe, frameSyncOe}, 32'h0);
		wr(CT, 32'h0);
		wr(CT, ON | FRM);
		rdc(ST, 32'h0000_00A8);
		report_and_stop();
	end
endmodule
